// [design/cwald_pkg.sv]
`default_nettype none
package cwald_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_INDEX    = 8'h30;
    localparam logic [7:0] OFF_TX_SECT  = 8'h34;
    localparam logic [7:0] OFF_RX_SECT  = 8'h38;
    localparam logic [7:0] OFF_ERR_CNT  = 8'h3c;
    localparam logic [7:0] OFF_FRAME_NO = 8'h40;
    localparam logic [7:0] OFF_LOOPBACK = 8'h44;
    localparam logic [7:0] OFF_CONFIG   = 8'h50;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h54;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h58;

    // Index register fields
    localparam int TX_X_LSB     = 0;
    localparam int TX_SEQ_LSB   = 8;
    localparam int TX_INS_BIT   = 11;
    localparam int RX_X_LSB     = 16;
    localparam int RX_SEQ_LSB   = 24;
    localparam logic [31:0] INDEX_MASK = 32'h07ff0fff;

    // Error counter fields
    localparam int LCV_LSB      = 0;
    localparam int SHV_LSB      = 8;

    // Loopback field and codes
    localparam int LOOP_LSB     = 8;
    localparam logic [2:0] LOOP_NONE  = 3'h0;
    localparam logic [2:0] LOOP_FULL  = 3'h1;
    localparam logic [2:0] LOOP_IQ    = 3'h2;
    localparam logic [2:0] LOOP_FCM   = 3'h3;
    localparam logic [2:0] LOOP_FCMVS = 3'h4;

    // Config register: global insert enable
    localparam int INS_EN_BIT   = 0;

    // Interrupt status bits
    localparam int IRQ_SHV      = 0;
    localparam int IRQ_LCV      = 1;
    localparam int IRQ_WRAP     = 2;
    localparam int IRQ_W        = 3;

    // Table sizes
    localparam int NUM_X        = 256;
    localparam int NUM_SEQ      = 5;
    localparam logic [2:0] SEQ_MAX = 3'h4;

    // Reset value and error counter maximum
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    localparam logic [7:0]  CNT_MAX    = 8'hff;

    // Word class on the link stream
    typedef enum logic [1:0] {
        CWALD_IQ,
        CWALD_CW_FCM,
        CWALD_CW_VS,
        CWALD_CW_OTHER
    } cwald_class_t;

    // One link word with its classification
    typedef struct packed {
        logic         valid;
        cwald_class_t kind;
        logic [31:0]  data;
    } cwald_word_t;

endpackage

`default_nettype wire

// [design/cwald_err_counter.sv]
`timescale 1ns/1ps
`default_nettype none

// Wrapping 8-bit event counter cleared by a read
module cwald_err_counter (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       pulse,
    input  wire logic       clear,
    output logic [7:0]      count,
    output logic            wrapped
);

    logic [7:0] count_q;
    logic [7:0] count_d;

    // An event in the clearing cycle is kept as a count of one
    assign count_d = clear ? {7'h00, pulse} : count_q + {7'h00, pulse};
    assign wrapped = pulse && !clear && (count_q == cwald_pkg::CNT_MAX);
    assign count   = count_q;

    // Counter register
    always_ff @(posedge clk) begin
        if (reset) begin
            count_q <= 8'h00;
        end else begin
            count_q <= count_d;
        end
    end

endmodule

`default_nettype wire

// [design/cwald_loop_mux.sv]
`timescale 1ns/1ps
`default_nettype none

// Selects, word by word, received or local content for the outgoing link
module cwald_loop_mux (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic [2:0]            mode,
    input  wire cwald_pkg::cwald_word_t rxWord,
    input  wire cwald_pkg::cwald_word_t localWord,
    output cwald_pkg::cwald_word_t     txWord
);

    logic takeRx;
    cwald_pkg::cwald_word_t txWord_q;

    // Returned word classes per mode; unknown codes fall back to local
    assign takeRx =
        (mode == cwald_pkg::LOOP_FULL) ||
        (mode == cwald_pkg::LOOP_IQ && rxWord.kind == cwald_pkg::CWALD_IQ) ||
        (mode == cwald_pkg::LOOP_FCM &&
         rxWord.kind == cwald_pkg::CWALD_CW_FCM) ||
        (mode == cwald_pkg::LOOP_FCMVS &&
         (rxWord.kind == cwald_pkg::CWALD_CW_FCM ||
          rxWord.kind == cwald_pkg::CWALD_CW_VS));

    // Registered output keeps the stream glitch free
    always_ff @(posedge clk) begin
        if (reset) begin
            txWord_q <= '0;
        end else begin
            txWord_q <= takeRx ? rxWord : localWord;
        end
    end

    assign txWord = txWord_q;

endmodule

`default_nettype wire

// [design/cwald_regs.sv]
// How it works
// - Writable transmit section stored to table entry at index and sequence
// - Read-only view of last received section at receive index and sequence
// - Accesses may take extra cycles; software waits for acknowledge
// - Sync-header violations counted in bits 15:8, read clears, wraps
// - Line-code violations counted in bits 7:0, read clears, wraps
// - Line-code violations during link bring-up are counted too
// - Current 12-bit frame number readable in bits 11:0
// - Selector one returns every incoming word unchanged
// - Selector two returns data words, control words generated locally
// - Selector three returns fast management words only
// - Selector four returns fast management and vendor words
// - Entry inserted only if its insert bit and global enable set
// - Transmit index bits 7:0 pick the control-word position
// - Three-bit sequence picks one of up to five sections
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module cwald_regs (
    input  wire logic                  clk,
    input  wire logic                  reset,
    // Wishbone classic slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    output logic                       wb_err_o,
    // Link side
    input  wire logic [7:0]            cwPosX,
    input  wire logic [2:0]            cwPosSeq,
    input  wire cwald_pkg::cwald_word_t rxWord,
    input  wire cwald_pkg::cwald_word_t localWord,
    input  wire logic                  syncHeaderViolation,
    input  wire logic                  lineCodeViolation,
    input  wire logic [11:0]           frameNumber,
    output cwald_pkg::cwald_word_t     txWord,
    output logic                       cwInsertValid,
    output logic [31:0]                cwInsertData,
    output logic                       irq
);

    // Tables held in flip-flops, indexed by position and section
    logic [31:0] txTable_q [cwald_pkg::NUM_X][cwald_pkg::NUM_SEQ];
    logic        txIns_q   [cwald_pkg::NUM_X][cwald_pkg::NUM_SEQ];
    logic [31:0] rxTable_q [cwald_pkg::NUM_X][cwald_pkg::NUM_SEQ];

    // Width of the status and mask words
    localparam int IRQ_W_L = cwald_pkg::IRQ_W;

    logic [31:0] index_q;
    logic [31:0] config_q;
    logic [2:0]  loop_q;
    logic [31:0] txSect_q;
    logic [IRQ_W_L-1:0] irqStat_q;
    logic [IRQ_W_L-1:0] irqMask_q;
    logic        ack_q;
    logic        err_q;
    logic [31:0] rdat_q;

    // Folds sequence numbers above the last section onto the last one
    function automatic logic [2:0] clampSeq(input logic [2:0] s);
        clampSeq = (s > cwald_pkg::SEQ_MAX) ? cwald_pkg::SEQ_MAX : s;
    endfunction

    // Byte-lane merge for Wishbone writes
    function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                              input logic [31:0] val,
                                              input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        laneMerge = (old & ~m) | (val & m);
    endfunction

    // Bus decode
    wire        req     = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    // Writes land at the edge that samples the acknowledge, while the
    // master still holds address, lanes and data
    wire        wr      = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
    wire        rd      = req && !wb_we_i;
    wire        hitIdx  = wb_adr_i == cwald_pkg::OFF_INDEX;
    wire        hitTx   = wb_adr_i == cwald_pkg::OFF_TX_SECT;
    wire        hitRx   = wb_adr_i == cwald_pkg::OFF_RX_SECT;
    wire        hitErr  = wb_adr_i == cwald_pkg::OFF_ERR_CNT;
    wire        hitFrm  = wb_adr_i == cwald_pkg::OFF_FRAME_NO;
    wire        hitLoop = wb_adr_i == cwald_pkg::OFF_LOOPBACK;
    wire        hitCfg  = wb_adr_i == cwald_pkg::OFF_CONFIG;
    wire        hitStat = wb_adr_i == cwald_pkg::OFF_IRQ_STAT;
    wire        hitMask = wb_adr_i == cwald_pkg::OFF_IRQ_MASK;
    wire        mapped  = hitIdx | hitTx | hitRx | hitErr | hitFrm |
                          hitLoop | hitCfg | hitStat | hitMask;

    wire [7:0]  txX     = index_q[cwald_pkg::TX_X_LSB +: 8];
    wire [2:0]  txSeq   = clampSeq(index_q[cwald_pkg::TX_SEQ_LSB +: 3]);
    // Receive view selects, folded like the transmit ones
    wire [7:0]  rxX     = index_q[cwald_pkg::RX_X_LSB +: 8];
    wire [2:0]  rxSeq   = clampSeq(index_q[cwald_pkg::RX_SEQ_LSB +: 3]);
    wire [2:0]  posSeq  = clampSeq(cwPosSeq);

    // Index writes reload the displayed section and its insert bit
    wire [31:0] idxNew  = laneMerge(index_q, wb_dat_i, wb_sel_i) &
                          cwald_pkg::INDEX_MASK;
    wire        idxWr   = wr && hitIdx;
    wire        txWr    = wr && hitTx;
    wire [7:0]  newX    = idxNew[cwald_pkg::TX_X_LSB +: 8];
    wire [2:0]  newSeq  = clampSeq(idxNew[cwald_pkg::TX_SEQ_LSB +: 3]);
    wire        newIns  = idxNew[cwald_pkg::TX_INS_BIT];
    wire        selMove = (newX != txX) || (newSeq != txSeq);

    // Error counters
    logic [7:0] shvCount;
    logic [7:0] lcvCount;
    logic       shvWrap;
    logic       lcvWrap;
    wire        errRd   = rd && hitErr;

    cwald_err_counter uShv (
        .clk     (clk),
        .reset   (reset),
        .pulse   (syncHeaderViolation),
        .clear   (errRd),
        .count   (shvCount),
        .wrapped (shvWrap)
    );

    // line-code counter, never gated by link state
    cwald_err_counter uLcv (
        .clk     (clk),
        .reset   (reset),
        .pulse   (lineCodeViolation),
        .clear   (errRd),
        .count   (lcvCount),
        .wrapped (lcvWrap)
    );

    cwald_loop_mux uLoop (
        .clk       (clk),
        .reset     (reset),
        .mode      (loop_q),
        .rxWord    (rxWord),
        .localWord (localWord),
        .txWord    (txWord)
    );

    // insertion gated by entry bit and global enable
    assign cwInsertValid = txIns_q[cwPosX][posSeq] &&
                           config_q[cwald_pkg::INS_EN_BIT];
    assign cwInsertData  = txTable_q[cwPosX][posSeq];

    // Interrupt events, sticky until written with one
    wire [IRQ_W_L-1:0] irqEvt = {shvWrap | lcvWrap, lineCodeViolation,
                                 syncHeaderViolation};
    wire [IRQ_W_L-1:0] irqClr = (wr && hitStat) ?
                                wb_dat_i[IRQ_W_L-1:0] : '0;
    assign irq = |(irqStat_q & irqMask_q);

    // Per-register read words, reserved bits tied to zero
    wire [31:0] rdIdxWord  = index_q |
                             {20'h00000, txIns_q[txX][txSeq], 11'h000};
    wire [31:0] rdErrWord  = {16'h0000, shvCount, lcvCount};
    wire [31:0] rdFrmWord  = {20'h00000, frameNumber};
    wire [31:0] rdLoopWord = {21'h000000, loop_q, 8'h00};
    wire [31:0] rdStatWord = {29'h0, irqStat_q};
    wire [31:0] rdMaskWord = {29'h0, irqMask_q};

    wire [31:0] rdMux =
        hitIdx  ? rdIdxWord :
        hitTx   ? txSect_q :
        hitRx   ? rxTable_q[rxX][rxSeq] :
        hitErr  ? rdErrWord :
        hitFrm  ? rdFrmWord :
        hitLoop ? rdLoopWord :
        hitCfg  ? config_q :
        hitStat ? rdStatWord :
        hitMask ? rdMaskWord : 32'h00000000;

    // one-cycle registered acknowledge, errors for unmapped addresses
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_q  <= 1'b0;
            err_q  <= 1'b0;
            rdat_q <= cwald_pkg::RESET_WORD;
        end else begin
            ack_q  <= req && mapped;
            err_q  <= req && !mapped;
            rdat_q <= rd ? rdMux : 32'h00000000;
        end
    end

    // Bus outputs come straight from flops
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdat_q;

    // Index register; the insert bit lives in the table, not here
    always_ff @(posedge clk) begin
        if (reset) begin
            index_q <= cwald_pkg::RESET_WORD;
        end else if (idxWr) begin
            index_q <= idxNew & ~(32'h1 << cwald_pkg::TX_INS_BIT);
        end
    end

    // Global insert enable, the only live bit of the config word
    always_ff @(posedge clk) begin
        if (reset) begin
            config_q <= cwald_pkg::RESET_WORD;
        end else if (wr && hitCfg) begin
            config_q <= {31'h0, wb_dat_i[cwald_pkg::INS_EN_BIT]};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            loop_q <= cwald_pkg::LOOP_NONE;
        end else if (wr && hitLoop && wb_sel_i[1]) begin
            loop_q <= wb_dat_i[cwald_pkg::LOOP_LSB +: 3];
        end
    end

    // Interrupt mask, written through lane 0 only
    always_ff @(posedge clk) begin
        if (reset) begin
            irqMask_q <= '0;
        end else if (wr && hitMask && wb_sel_i[0]) begin
            irqMask_q <= wb_dat_i[IRQ_W_L-1:0];
        end
    end

    // Sticky status: a new event wins over a clear
    always_ff @(posedge clk) begin
        if (reset) begin
            irqStat_q <= '0;
        end else begin
            irqStat_q <= (irqStat_q & ~irqClr) | irqEvt;
        end
    end

    // transmit section holds the selected entry
    always_ff @(posedge clk) begin
        if (reset) begin
            txSect_q <= cwald_pkg::RESET_WORD;
        end else if (txWr) begin
            txSect_q <= laneMerge(txSect_q, wb_dat_i, wb_sel_i);
        end else if (idxWr && selMove) begin
            txSect_q <= txTable_q[newX][newSeq];
        end
    end

    // table store at current index and sequence
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int x = 0; x < cwald_pkg::NUM_X; x++) begin
                for (int s = 0; s < cwald_pkg::NUM_SEQ; s++) begin
                    txTable_q[x][s] <= cwald_pkg::RESET_WORD;
                    txIns_q[x][s]   <= 1'b0;
                end
            end
        end else begin
            if (txWr) begin
                txTable_q[txX][txSeq] <=
                    laneMerge(txSect_q, wb_dat_i, wb_sel_i);
            end
            // Insert bit belongs to the newly indexed entry
            if (idxWr && wb_sel_i[1]) begin
                txIns_q[newX][newSeq] <= newIns;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int x = 0; x < cwald_pkg::NUM_X; x++) begin
                for (int s = 0; s < cwald_pkg::NUM_SEQ; s++) begin
                    rxTable_q[x][s] <= cwald_pkg::RESET_WORD;
                end
            end
        end else if (rxWord.valid && rxWord.kind != cwald_pkg::CWALD_IQ) begin
            rxTable_q[cwPosX][posSeq] <= rxWord.data;
        end
    end

endmodule

`default_nettype wire

// [testbench/cwald_regs_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of bus timing, read content and loopback choice
module cwald_regs_assertions (
    input wire logic                   clk,
    input wire logic                   reset,
    input wire logic                   wb_cyc_i,
    input wire logic                   wb_stb_i,
    input wire logic                   wb_we_i,
    input wire logic [7:0]             wb_adr_i,
    input wire logic [3:0]             wb_sel_i,
    input wire logic [31:0]            wb_dat_i,
    input wire logic [31:0]            wb_dat_o,
    input wire logic                   wb_ack_o,
    input wire logic                   wb_err_o,
    input wire logic [7:0]             cwPosX,
    input wire logic [2:0]             cwPosSeq,
    input wire cwald_pkg::cwald_word_t rxWord,
    input wire cwald_pkg::cwald_word_t localWord,
    input wire logic                   syncHeaderViolation,
    input wire logic                   lineCodeViolation,
    input wire logic [11:0]            frameNumber,
    input wire cwald_pkg::cwald_word_t txWord,
    input wire logic                   cwInsertValid,
    input wire logic [31:0]            cwInsertData,
    input wire logic                   irq
);
    logic       taken;
    logic       mapped;
    logic       pickRx;
    logic [2:0] modeQ;
    logic [7:0] lcvQ;
    logic [7:0] shvQ;

    // Request accepted at this edge, address decode, loopback pick
    assign taken  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign mapped = wb_adr_i inside {8'h30, 8'h34, 8'h38, 8'h3c, 8'h40,
                                     8'h44, 8'h50, 8'h54, 8'h58};
    assign pickRx = (modeQ == 3'h1) | (modeQ == 3'h2 && rxWord.kind == 2'h0)
                  | (modeQ == 3'h3 && rxWord.kind == 2'h1)
                  | (modeQ == 3'h4 && rxWord.kind inside {2'h1, 2'h2});

    // Shadow selector and counts; a read restarts both counts
    always_ff @(posedge clk) begin
        if (reset) begin
            modeQ <= 3'h0;
            lcvQ <= 8'h0;
            shvQ <= 8'h0;
        end else begin
            // Writes land at the acknowledge edge
            if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
                wb_adr_i == 8'h44 && wb_sel_i[1]) begin
                modeQ <= wb_dat_i[10:8];
            end
            if (taken && !wb_we_i && wb_adr_i == 8'h3c) begin
                lcvQ <= {7'h0, lineCodeViolation};
                shvQ <= {7'h0, syncHeaderViolation};
            end else begin
                lcvQ <= lcvQ + {7'h0, lineCodeViolation};
                shvQ <= shvQ + {7'h0, syncHeaderViolation};
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_answer_next: assert property (taken |=> wb_ack_o != wb_err_o)
        else $error("request not answered by one pulse");
    a_unmapped_err: assert property (taken && !mapped |=> wb_err_o)
        else $error("unmapped address not refused");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_idle_quiet: assert property (!(wb_cyc_i && wb_stb_i) |=>
        !wb_ack_o && !wb_err_o) else $error("answer without request");
    a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside acknowledge");
    a_frame_read: assert property (taken && !wb_we_i
        && wb_adr_i == 8'h40 |=> wb_dat_o == {20'h0, $past(frameNumber)})
        else $error("frame number read wrong");
    a_count_read: assert property (taken && !wb_we_i
        && wb_adr_i == 8'h3c
        |=> wb_dat_o == {16'h0, $past(shvQ), $past(lcvQ)})
        else $error("error counts read wrong");
    a_loop_pick: assert property (!$past(reset)
        |-> txWord == $past(pickRx ? rxWord : localWord))
        else $error("outgoing word from wrong source");
endmodule

bind cwald_regs cwald_regs_assertions u_chk (
    .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .cwPosX(cwPosX), .cwPosSeq(cwPosSeq),
    .rxWord(rxWord), .localWord(localWord),
    .syncHeaderViolation(syncHeaderViolation),
    .lineCodeViolation(lineCodeViolation), .frameNumber(frameNumber),
    .txWord(txWord), .cwInsertValid(cwInsertValid),
    .cwInsertData(cwInsertData), .irq(irq));
`default_nettype wire

// [testbench/cwald_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module cwald_regs_tb;
    logic                   clk;
    logic                   reset;
    logic                   wb_cyc_i, wb_stb_i, wb_we_i, er;
    logic [7:0]             wb_adr_i, cwPosX;
    logic [3:0]             wb_sel_i;
    logic [31:0]            wb_dat_i, wb_dat_o, cwInsertData, rd;
    logic                   wb_ack_o, wb_err_o, cwInsertValid, irq;
    logic [2:0]             cwPosSeq;
    logic                   syncHeaderViolation, lineCodeViolation;
    logic [11:0]            frameNumber;
    cwald_pkg::cwald_word_t rxWord, localWord, txWord;
    int                     miscompares = 0;
    int                     numChecks = 0;
    int                     cycles = 0;

    cwald_regs u_dut (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .cwPosX(cwPosX),
        .cwPosSeq(cwPosSeq), .rxWord(rxWord), .localWord(localWord),
        .syncHeaderViolation(syncHeaderViolation),
        .lineCodeViolation(lineCodeViolation), .frameNumber(frameNumber),
        .txWord(txWord), .cwInsertValid(cwInsertValid),
        .cwInsertData(cwInsertData), .irq(irq));

    // 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Cuts a hung run short; the whole run needs about 800 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (miscompares == 0 && numChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compares any value up to one link word wide
    task automatic chk(input logic [34:0] got, input logic [34:0] exp);
        numChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Classic single cycle; held until acknowledge or error is sampled
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do @(posedge clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        // One idle edge lets the write settle before the caller looks
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, 4'hf, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 4'hf, 32'h0);
        chk({3'h0, rd}, {3'h0, exp});
    endtask

    // Table write lands at the indexed entry; sequence 7 acts as 4
    task automatic t_tx_table();
        wr(8'h30, 32'h0000_0205);
        wr(8'h34, 32'hcafe_0001);
        wr(8'h30, 32'h0000_0405);
        rdchk(8'h34, 32'h0);
        wr(8'h34, 32'h1234_5678);
        wr(8'h30, 32'h0000_0206);
        rdchk(8'h34, 32'h0);
        wr(8'h30, 32'h0000_0205);
        rdchk(8'h34, 32'hcafe_0001);
        wr(8'h30, 32'h0000_0705);
        rdchk(8'h34, 32'h1234_5678);
        wr(8'h30, 32'hf8f3_f3aa);
        rdchk(8'h30, 32'h00f3_03aa);
    endtask

    // Insertion needs the entry bit and the global enable together
    task automatic t_insert();
        wr(8'h30, 32'h0000_0909);
        wr(8'h34, 32'h5a5a_0009);
        cwPosX <= 8'h09;
        cwPosSeq <= 3'h1;
        @(posedge clk);
        chk(cwInsertValid, 1'b0);
        wr(8'h50, 32'h1);
        chk(cwInsertValid, 1'b1);
        chk(cwInsertData, 32'h5a5a_0009);
        wr(8'h30, 32'h0000_0109);
        chk(cwInsertValid, 1'b0);
    endtask

    // Received section shows at the receive index; writes are ignored
    task automatic t_rx_table();
        cwPosX <= 8'h07;
        rxWord <= '{1'b1, cwald_pkg::CWALD_CW_FCM, 32'hbeef_0007};
        @(posedge clk);
        rxWord <= '{1'b0, cwald_pkg::CWALD_IQ, 32'h0};
        wr(8'h30, 32'h0107_0000);
        wr(8'h38, 32'h0);
        rdchk(8'h38, 32'hbeef_0007);
    endtask

    // 257 line-code events wrap to 1; read clears; status and mask
    task automatic t_counters();
        for (int i = 0; i < 257; i++) begin
            @(posedge clk);
            lineCodeViolation <= 1'b1;
            syncHeaderViolation <= (i < 3);
            @(posedge clk);
            lineCodeViolation <= 1'b0;
            syncHeaderViolation <= 1'b0;
        end
        chk(irq, 1'b0);
        rdchk(8'h3c, 32'h0000_0301);
        rdchk(8'h3c, 32'h0);
        rdchk(8'h54, 32'h7);
        wr(8'h58, 32'h2);
        chk(irq, 1'b1);
        wr(8'h54, 32'h7);
        chk(irq, 1'b0);
    endtask

    // Read-only frame number, reserved bits zero; unmapped refused
    task automatic t_frame();
        frameNumber <= 12'habc;
        wr(8'h40, 32'hffff_ffff);
        rdchk(8'h40, 32'h0000_0abc);
        bus(1'b0, 8'h60, 4'hf, 32'h0);
        chk(er, 1'b1);
        wr(8'h48, 32'hffff_ffff);
        chk(er, 1'b1);
    endtask

    // Every selector value against every word class
    task automatic t_loop();
        logic sel;
        for (int m = 0; m < 8; m++) begin
            wr(8'h44, 32'hffff_f8ff | (m << 8));
            rdchk(8'h44, m << 8);
            for (int k = 0; k < 4; k++) begin
                sel = m == 1 || (m == 2 && k == 0) || (m == 3 && k == 1)
                      || (m == 4 && (k == 1 || k == 2));
                rxWord <= {1'b1, 2'(k), 32'h1000_0000 + m};
                localWord <= {1'b1, 2'h3, 32'h2000_0000 + k};
                @(posedge clk);
                @(posedge clk);
                chk(txWord, sel ? {1'b1, 2'(k), 32'h1000_0000 + m}
                    : {1'b1, 2'h3, 32'h2000_0000 + k});
            end
        end
        wr(8'h44, 32'h0);
    endtask

    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, syncHeaderViolation} = 4'h0;
        {wb_adr_i, cwPosX, wb_sel_i, cwPosSeq, lineCodeViolation} = 24'h0;
        {wb_dat_i, frameNumber, rxWord, localWord} = 114'h0;
        reset = 1'b1;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rdchk(8'h34, 32'h0);
        rdchk(8'h3c, 32'h0);
        rdchk(8'h44, 32'h0);
        t_tx_table();
        t_insert();
        t_rx_table();
        t_counters();
        t_frame();
        t_loop();
        wrap_up();
    end
endmodule
`default_nettype wire
